//--- hw/burst_store.sv
/*
 * single-port-write, registered-read storage for one row per bank
 * assumes write and read addresses are driven on the same clock
 */
`timescale 1ns/10ps
`default_nettype none
module burst_store
    import sdram_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                wr_en_in,
    input  wire logic [STORE_AW-1:0] addr_in,
    input  wire logic [DATA_W-1:0]   wr_data_in,
    output logic      [DATA_W-1:0]   rd_data_out
);
    logic [DATA_W-1:0] mem_ff [0:(1<<STORE_AW)-1];
    logic [DATA_W-1:0] rd_ff;

    // write port and registered read port
    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem_ff[addr_in] <= wr_data_in;
        end
        rd_ff <= mem_ff[addr_in];
    end

    assign rd_data_out = rd_ff;
endmodule // burst_store
`default_nettype wire

//--- hw/sdram_core.sv
/*
 * command decode, bank row tracking, burst column engine and data path of a
 * four-bank sdram; mode settings arrive as static inputs on the same clock
 * assumes the controller drives all command pins valid at each rising edge
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - all command, address and data inputs are sampled on the rising clock edge
// - four independent banks, each selected by bank bits, each holding one open row
// - 8192 rows per bank; 2048x4, 1024x8 or 512x16 columns
// - activate takes bank from the bank bits and row from thirteen address bits
// - read or write address gives the burst's first column in the open row
// - burst walks the programmed count in programmed order, columns made internally
// - burst length is 1, 2, 4, 8 or full page for reads and writes
// - full-page burst runs on until the controller sends burst terminate
// - auto precharge closes the row itself when the burst completes
// - a new column address is accepted on every clock cycle
// - one bank may be precharged or opened while another is accessed
// - auto refresh and power-down modes exist beside normal access
// - chip select high ignores commands; running bursts and data mask continue
// - precharge with bit 10 high closes every bank, low closes only one
// - mask blocks write data now, blanks read drivers two clocks later
module sdram_core
    import sdram_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              nrst_in,
    input  wire logic              cke_in,
    input  wire logic              cs_n_in,
    input  wire logic              ras_n_in,
    input  wire logic              cas_n_in,
    input  wire logic              we_n_in,
    input  wire logic [BANK_W-1:0] ba_in,
    input  wire logic [ROW_W-1:0]  addr_in,
    input  wire logic              dqm_in,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic [2:0]        burst_length_setting_in,
    input  wire logic              interleave_in,
    input  wire logic              extended_temp_variant_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe_out,
    output logic      [BANKS-1:0]  bank_open_out,
    output logic                   burst_active_out,
    output logic                   power_down_out,
    output logic                   self_refresh_out,
    output logic      [ROW_W-1:0]  refresh_count_out
);
    // command code, chip select high counts as no operation
    function automatic cmd_type decode_cmd(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
        decode_cmd = cs_n ? CMD_NOP : cmd_type'({ras_n, cas_n, we_n});
    endfunction

    // burst length from the setting code
    function automatic logic [CNT_W-1:0] len_of(input logic [2:0] code);
        case (code)
            BL_1:    len_of = 10'h001;
            BL_2:    len_of = 10'h002;
            BL_4:    len_of = 10'h004;
            BL_8:    len_of = 10'h008;
            default: len_of = PAGE_LEN;
        endcase
    endfunction

    // column of beat cnt, wrapping inside the burst-sized block
    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start, input logic [CNT_W-1:0] cnt,
                                                input logic [CNT_W-1:0] len, input logic ilv);
        logic [COL_W-1:0] mask;
        logic [COL_W-1:0] step;
        mask = COL_W'(len - 10'h001);
        step = cnt[COL_W-1:0];
        if (ilv && len != PAGE_LEN) begin
            col_of = (start & ~mask) | ((start ^ step) & mask);
        end else begin
            col_of = (start & ~mask) | (COL_W'(start + step) & mask);
        end
    endfunction

    logic                   rs_meta_ff;
    logic                   rst_n_ff;
    logic [BANKS-1:0]       open_ff, nxt_open;
    logic [ROW_W-1:0]       row_ff [BANKS];
    logic [ROW_W-1:0]       nxt_row [BANKS];
    burst_state_type        state_ff, nxt_state;
    logic [COL_W-1:0]       start_ff, nxt_start;
    logic [CNT_W-1:0]       cnt_ff, nxt_cnt, len_ff, nxt_len;
    logic                   ilv_ff, nxt_ilv, ap_ff, nxt_ap;
    logic [BANK_W-1:0]      bank_ff, nxt_bank;
    pwr_state_type          pwr_ff, nxt_pwr;
    logic [ROW_W-1:0]       rcnt_ff, nxt_rcnt;
    logic                   rv_ff, dqm_d1_ff, oe_ff, bact_ff, pd_ff, sr_ff;
    logic [DATA_W-1:0]      dq_ff;
    logic [DATA_W-1:0]      rd_data;
    cmd_type                cmd_raw, cmd;
    logic                   cmd_rw, beat, beat_wr, beat_rd, suspend, end_close;
    logic [COL_W-1:0]       beat_col;
    logic [BANK_W-1:0]      beat_bank;

    // asynchronous assertion, two-flop release
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rs_meta_ff <= 1'b0;
            rst_n_ff   <= 1'b0;
        end else begin
            rs_meta_ff <= 1'b1;
            rst_n_ff   <= rs_meta_ff;
        end
    end

    // command qualification and current beat
    always_comb begin
        cmd_raw   = decode_cmd(cs_n_in, ras_n_in, cas_n_in, we_n_in);
        cmd       = (cke_in && pwr_ff == PWR_RUN) ? cmd_raw : CMD_NOP;
        cmd_rw    = (cmd == CMD_READ || cmd == CMD_WRITE) && open_ff[ba_in];
        suspend   = !cke_in;
        beat      = cmd_rw || (state_ff != BURST_IDLE && !suspend);
        beat_wr   = beat && (cmd_rw ? cmd == CMD_WRITE : state_ff == BURST_WRITE);
        beat_rd   = beat && !beat_wr;
        beat_col  = cmd_rw ? addr_in[COL_W-1:0] : col_of(start_ff, cnt_ff, len_ff, ilv_ff);
        beat_bank = cmd_rw ? ba_in : bank_ff;
    end

    // burst engine next state
    always_comb begin
        nxt_state = state_ff;
        nxt_start = start_ff;
        nxt_cnt   = cnt_ff;
        nxt_len   = len_ff;
        nxt_ilv   = ilv_ff;
        nxt_ap    = ap_ff;
        nxt_bank  = bank_ff;
        end_close = 1'b0;
        if (cmd_rw) begin
            nxt_start = addr_in[COL_W-1:0];
            nxt_len   = len_of(burst_length_setting_in);
            nxt_ilv   = interleave_in;
            nxt_ap    = addr_in[AUTO_PRECHARGE_ALL_BANKS_BIT];
            nxt_bank  = ba_in;
            nxt_cnt   = 10'h001;
            if (nxt_len == 10'h001) begin
                nxt_state = BURST_IDLE;
                end_close = nxt_ap;
            end else begin
                nxt_state = (cmd == CMD_WRITE) ? BURST_WRITE : BURST_READ;
            end
        end else if (cmd == CMD_TERMINATE) begin
            nxt_state = BURST_IDLE;
        end else if (cmd == CMD_PRECHARGE && (addr_in[AUTO_PRECHARGE_ALL_BANKS_BIT] || ba_in == bank_ff)) begin
            nxt_state = BURST_IDLE;
        end else if (state_ff != BURST_IDLE && !suspend) begin
            if (len_ff != PAGE_LEN && cnt_ff == len_ff - 10'h001) begin
                nxt_state = BURST_IDLE;
                end_close = ap_ff;
            end else begin
                nxt_cnt = cnt_ff + 10'h001;
            end
        end
    end

    // bank rows: activate, precharge, self-timed close
    always_comb begin
        nxt_open = open_ff;
        for (int b = 0; b < BANKS; b++) begin
            nxt_row[b] = row_ff[b];
        end
        if (cmd == CMD_ACTIVATE && !open_ff[ba_in]) begin
            nxt_open[ba_in] = 1'b1;
            nxt_row[ba_in]  = addr_in;
        end
        if (cmd == CMD_PRECHARGE) begin
            if (addr_in[AUTO_PRECHARGE_ALL_BANKS_BIT]) begin
                nxt_open = RST_OPEN;
            end else begin
                nxt_open[ba_in] = 1'b0;
            end
        end
        if (end_close) begin
            nxt_open[cmd_rw ? ba_in : bank_ff] = 1'b0;
        end
    end

    // refresh and power modes
    always_comb begin
        nxt_pwr  = pwr_ff;
        nxt_rcnt = rcnt_ff;
        case (pwr_ff)
            PWR_RUN: begin
                if (cmd == CMD_REFRESH && open_ff == RST_OPEN) begin
                    nxt_rcnt = rcnt_ff + 13'h0001;
                end
                if (!cke_in && state_ff == BURST_IDLE) begin
                    if (cmd_raw == CMD_REFRESH && open_ff == RST_OPEN && !extended_temp_variant_in) begin
                        nxt_pwr = PWR_SELF;
                    end else begin
                        nxt_pwr = PWR_DOWN;
                    end
                end
            end
            default: begin
                if (cke_in) begin
                    nxt_pwr = PWR_RUN;
                end
            end
        endcase
    end

    // control registers
    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            open_ff  <= RST_OPEN;
            state_ff <= BURST_IDLE;
            start_ff <= RST_COL;
            cnt_ff   <= RST_CNT;
            len_ff   <= RST_CNT;
            ilv_ff   <= 1'b0;
            ap_ff    <= 1'b0;
            bank_ff  <= 2'h0;
            pwr_ff   <= PWR_RUN;
            rcnt_ff  <= RST_ROW;
            rv_ff    <= 1'b0;
            dqm_d1_ff <= 1'b0;
            oe_ff    <= 1'b0;
            bact_ff  <= 1'b0;
            pd_ff    <= 1'b0;
            sr_ff    <= 1'b0;
            dq_ff    <= RST_DATA;
            for (int b = 0; b < BANKS; b++) begin
                row_ff[b] <= RST_ROW;
            end
        end else begin
            open_ff  <= nxt_open;
            state_ff <= nxt_state;
            start_ff <= nxt_start;
            cnt_ff   <= nxt_cnt;
            len_ff   <= nxt_len;
            ilv_ff   <= nxt_ilv;
            ap_ff    <= nxt_ap;
            bank_ff  <= nxt_bank;
            pwr_ff   <= nxt_pwr;
            rcnt_ff  <= nxt_rcnt;
            rv_ff    <= beat_rd;
            dqm_d1_ff <= dqm_in;
            oe_ff    <= rv_ff && !dqm_d1_ff;
            bact_ff  <= (nxt_state != BURST_IDLE);
            pd_ff    <= (nxt_pwr == PWR_DOWN);
            sr_ff    <= (nxt_pwr == PWR_SELF);
            dq_ff    <= rd_data;
            for (int b = 0; b < BANKS; b++) begin
                row_ff[b] <= nxt_row[b];
            end
        end
    end

    // column storage, write masked by dqm
    burst_store u_store (
        .clock_in    (clock_in),
        .wr_en_in    (beat_wr && !dqm_in),
        .addr_in     ({beat_bank, beat_col}),
        .wr_data_in  (dq_in),
        .rd_data_out (rd_data)
    );

    assign dq_out            = dq_ff;
    assign dq_oe_out         = oe_ff;
    assign bank_open_out     = open_ff;
    assign burst_active_out  = bact_ff;
    assign power_down_out    = pd_ff;
    assign self_refresh_out  = sr_ff;
    assign refresh_count_out = rcnt_ff;

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_ff);

    a_act_opens_row: assert property (cmd == CMD_ACTIVATE && !open_ff[ba_in] |=>
        open_ff[$past(ba_in)] && row_ff[$past(ba_in)] == $past(addr_in)) else $error("activate did not open row");
    a_pre_all_banks: assert property (cmd == CMD_PRECHARGE && addr_in[10]
        |=> open_ff == 4'h0) else $error("precharge all left a bank open");
    a_pre_one_bank: assert property (cmd == CMD_PRECHARGE && !addr_in[10] && cmd != CMD_ACTIVATE
        |=> !open_ff[$past(ba_in)]) else $error("precharge left bank open");
    a_dqm_read_hiz: assert property (beat_rd && dqm_in |-> ##2 !dq_oe_out) else $error("masked read drove data");
    a_read_drives: assert property (beat_rd && !dqm_in |-> ##2 dq_oe_out) else $error("read beat not driven");
    a_cs_ignores: assert property (cs_n_in && state_ff == BURST_IDLE |=>
        state_ff == BURST_IDLE && open_ff == $past(open_ff)) else $error("command taken with chip select high");
    a_first_column: assert property (cmd_rw |-> beat_col == addr_in[8:0]) else $error("first column wrong");
    a_burst_four: assert property (cmd == CMD_READ && cmd_rw && burst_length_setting_in == 3'h2
        ##1 (cke_in && cmd == CMD_NOP)[*3] |=> state_ff == BURST_IDLE) else $error("length four burst wrong length");
    a_terminate_ends: assert property (cmd == CMD_TERMINATE && !cmd_rw |=> state_ff == BURST_IDLE)
        else $error("terminate did not end burst");
    a_auto_close: assert property (state_ff != BURST_IDLE && ap_ff && cke_in && cmd == CMD_NOP
        && len_ff != 10'h200 && cnt_ff == len_ff - 10'h001 |=> !open_ff[$past(bank_ff)]) else $error("auto precharge missed");
    a_no_self_ext: assert property (extended_temp_variant_in && pwr_ff == PWR_RUN |=> !self_refresh_out)
        else $error("self refresh on extended variant");

    c_read_burst: cover property (cmd == CMD_READ && cmd_rw ##1 burst_active_out ##2 dq_oe_out);
    c_write_burst: cover property (cmd == CMD_WRITE && cmd_rw ##1 state_ff == BURST_WRITE);
    c_page_term: cover property (len_ff == 10'h200 && burst_active_out ##1 cmd == CMD_TERMINATE);
    c_interleave: cover property (burst_active_out ##0 cmd == CMD_ACTIVATE && ba_in != bank_ff);
endmodule // sdram_core
`default_nettype wire

//--- shared/sdram_pkg.sv
/*
 * constants, encodings and state types for the four-bank sdram core model
 * assumes a 16-bit wide organisation and one system clock
 */
`default_nettype none
package sdram_pkg;
    // array shape
    localparam int BANKS     = 4;
    localparam int BANK_W    = 2;
    localparam int ROWS      = 8192;
    localparam int ROW_W     = 13;
    localparam int COLS_X4   = 2048;
    localparam int COLS_X8   = 1024;
    localparam int COLS      = 512;    // x16 organisation is the one built
    localparam int COL_W     = 9;
    localparam int DATA_W    = 16;
    localparam int STORE_AW  = BANK_W + COL_W;
    localparam int CNT_W     = 10;
    localparam int AUTO_PRECHARGE_ALL_BANKS_BIT = 10;
    localparam int DQM_LATENCY = 2;    // clocks from mask to high impedance
    // burst length setting codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [CNT_W-1:0] PAGE_LEN = 10'h200;
    // values after reset
    localparam logic [BANKS-1:0]   RST_OPEN = 4'h0;
    localparam logic [ROW_W-1:0]   RST_ROW  = 13'h0000;
    localparam logic [CNT_W-1:0]   RST_CNT  = 10'h000;
    localparam logic [COL_W-1:0]   RST_COL  = 9'h000;
    localparam logic [DATA_W-1:0]  RST_DATA = 16'h0000;
    // commands as {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        CMD_MODE      = 3'h0,
        CMD_REFRESH   = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE  = 3'h3,
        CMD_WRITE     = 3'h4,
        CMD_READ      = 3'h5,
        CMD_TERMINATE = 3'h6,
        CMD_NOP       = 3'h7
    } cmd_type;
    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_READ  = 2'b01,
        BURST_WRITE = 2'b11
    } burst_state_type;
    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_SELF = 2'b11
    } pwr_state_type;
endpackage
`default_nettype wire

//--- verification/sdram_bank_burst_access_bench.sv
/*
 * self-checking bench for the sdram core, driven through the controller model
 * assumes the two-flop reset release and the read pipeline of two clocks
 */
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_burst_access_bench;
    import sdram_pkg::*;
    logic             clock_in = 1'b0;
    logic             nrst_in  = 1'b0;
    logic [2:0]       bl       = 3'h0;
    logic             ilv      = 1'b0;
    logic             ext      = 1'b0;
    wire logic        cke, cs_n, ras_n, cas_n, we_n, dqm, oe, bact, pd, sr;
    wire logic [1:0]  ba;
    wire logic [12:0] addr, rcnt;
    wire logic [15:0] dq_w, dq_r;
    wire logic [3:0]  bopen;
    logic [15:0]      mem [4][512];
    int               n_errors = 0;
    int               n_compared = 0;

    // 40 mhz clock
    always #12.5 clock_in = ~clock_in;

    sdram_ctrl_model ctrl (.clock_in(clock_in), .extended_temp_variant_in(ext), .cke_out(cke),
        .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
        .addr_out(addr), .dqm_out(dqm), .dq_out(dq_w));
    sdram_core dut (.clock_in(clock_in), .nrst_in(nrst_in), .cke_in(cke), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
        .dqm_in(dqm), .dq_in(dq_w), .burst_length_setting_in(bl), .interleave_in(ilv),
        .extended_temp_variant_in(ext), .dq_out(dq_r), .dq_oe_out(oe), .bank_open_out(bopen),
        .burst_active_out(bact), .power_down_out(pd), .self_refresh_out(sr),
        .refresh_count_out(rcnt));

    // verdict and end of run
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // idle cycle: deselected, data lines flip so stale values never match
    task automatic nop();
        ctrl.send(CMD_NOP, 2'h0, 13'h0, ~dq_w, 1'b0, 1'b1);
    endtask

    function automatic logic [8:0] col_of(input logic [8:0] s, input int k, input int len, input logic i);
        logic [8:0] m;
        m = 9'(len - 1);
        return (s & ~m) | ((i ? (s ^ 9'(k)) : (s + 9'(k))) & m);
    endfunction

    // write burst of n beats; masked beats leave the model untouched
    task automatic wr(input logic [1:0] b, input logic [8:0] s, input logic [2:0] code, input int n,
                      input logic i, input logic [7:0] msk);
        logic [15:0] d;
        int          len;
        len = (code == BL_PAGE) ? 512 : (1 << code);
        bl = code;
        ilv = i;
        for (int k = 0; k < n; k++) begin
            d = {b, s[4:0], 9'(k)};
            ctrl.send(k == 0 ? CMD_WRITE : CMD_NOP, b, {4'h0, s}, d, msk[k], 1'b0);
            if (!msk[k]) mem[b][col_of(s, k, len, i)] = d;
        end
        if (code == BL_PAGE) ctrl.send(CMD_TERMINATE, b, 13'h0, d, 1'b1, 1'b0);
        nop();
    endtask

    // read burst; beat k seen two clocks after it is taken
    task automatic rd(input logic [1:0] b, input logic [8:0] s, input logic [2:0] code, input int n,
                      input logic i, input logic ap, input logic [15:0] rm);
        int len;
        len = (code == BL_PAGE) ? 512 : (1 << code);
        bl = code;
        ilv = i;
        for (int j = 0; j < n + 2; j++) begin
            ctrl.send(j == 0 ? CMD_READ : CMD_NOP, b, {2'h0, ap, 1'b0, s}, ~dq_w, rm[j], 1'b0);
            #1;
            if (j >= 2) begin
                cmp(16'(oe), 16'(!rm[j-2]), "read drive");
                if (!rm[j-2]) cmp(dq_r, mem[b][col_of(s, j - 2, len, i)], "read data");
            end
        end
        if (code != BL_PAGE) begin
            nop();
            #1;
            cmp(16'(oe), 16'h0, "burst end");
        end
    endtask

    task automatic t_open();
        cmp(16'(bopen), 16'h0, "banks after reset");
        cmp(16'(rcnt), 16'h0, "refresh after reset");
        ctrl.send(CMD_ACTIVATE, 2'h0, 13'h1abc, ~dq_w, 1'b0, 1'b0);
        ctrl.send(CMD_ACTIVATE, 2'h2, 13'h0fff, ~dq_w, 1'b0, 1'b0);
        nop();
        #1;
        cmp(16'(bopen), 16'h5, "banks opened");
    endtask

    task automatic t_burst();
        wr(2'h0, 9'h000, BL_8, 8, 1'b0, 8'h00);
        wr(2'h0, 9'h005, BL_4, 4, 1'b0, 8'h02);
        wr(2'h2, 9'h003, BL_8, 8, 1'b1, 8'h00);
        rd(2'h0, 9'h000, BL_8, 8, 1'b0, 1'b0, 16'h0);
        for (int c = 0; c < 4; c++) begin
            rd(2'h0, 9'h005, 3'(c), 1 << c, 1'b0, 1'b0, 16'h0);
            rd(2'h2, 9'h003, 3'(c), 1 << c, 1'b1, 1'b0, 16'h0);
        end
        rd(2'h0, 9'h000, BL_4, 4, 1'b0, 1'b0, 16'h0004);
    endtask

    task automatic t_page_cs();
        wr(2'h0, 9'h1fe, BL_PAGE, 4, 1'b0, 8'h00);
        rd(2'h0, 9'h1fe, BL_PAGE, 4, 1'b0, 1'b0, 16'h0);
        cmp(16'(bact), 16'h1, "page still running");
        ctrl.send(CMD_TERMINATE, 2'h0, 13'h0, ~dq_w, 1'b0, 1'b0);
        nop();
        #1;
        cmp(16'(bact), 16'h0, "page terminated");
        ctrl.send(CMD_READ, 2'h0, 13'h0, ~dq_w, 1'b0, 1'b1);
        repeat (4) begin
            nop();
            #1;
            cmp(16'(oe), 16'h0, "deselected read");
        end
    endtask

    task automatic t_close();
        rd(2'h2, 9'h003, BL_2, 2, 1'b0, 1'b1, 16'h0);
        cmp(16'(bopen), 16'h1, "auto close");
        ctrl.send(CMD_ACTIVATE, 2'h1, 13'h0001, ~dq_w, 1'b0, 1'b0);
        ctrl.send(CMD_ACTIVATE, 2'h3, 13'h1fff, ~dq_w, 1'b0, 1'b0);
        ctrl.send(CMD_PRECHARGE, 2'h0, 13'h0000, ~dq_w, 1'b0, 1'b0);
        nop();
        #1;
        cmp(16'(bopen), 16'ha, "one bank closed");
        ctrl.send(CMD_PRECHARGE, 2'h1, 13'h0400, ~dq_w, 1'b0, 1'b0);
        nop();
        #1;
        cmp(16'(bopen), 16'h0, "all banks closed");
    endtask

    task automatic t_power();
        ctrl.send(CMD_REFRESH, 2'h0, 13'h0, ~dq_w, 1'b0, 1'b0);
        ctrl.send(CMD_REFRESH, 2'h0, 13'h0, ~dq_w, 1'b0, 1'b0);
        nop();
        #1;
        cmp(16'(rcnt), 16'h2, "refresh count");
        ctrl.set_cke(1'b0);
        nop();
        nop();
        #1;
        cmp(16'(pd), 16'h1, "power down");
        cmp(16'(sr), 16'h0, "no self refresh");
        ctrl.set_cke(1'b1);
        nop();
        nop();
        #1;
        cmp(16'(pd), 16'h0, "power up");
        ctrl.enter_self();
        nop();
        #1;
        cmp(16'(sr), 16'h1, "self refresh");
        ctrl.set_cke(1'b1);
        nop();
        #1;
        cmp(16'(sr), 16'h0, "self refresh exit");
        ext = 1'b1;
        ctrl.enter_self();
        nop();
        #1;
        cmp(16'(sr), 16'h0, "variant self refresh");
        cmp(16'(pd), 16'h1, "variant power down");
        cmp(16'(rcnt), 16'h2, "refresh count kept");
        ctrl.set_cke(1'b1);
        nop();
        #1;
        cmp(16'(pd), 16'h0, "variant power up");
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clock_in);
        #1;
        nrst_in = 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        t_open();
        t_burst();
        t_page_cs();
        t_close();
        t_power();
        results();
    end

    // watchdog far beyond the roughly 150 cycles the tests need
    initial begin
        #50000;
        n_errors++;
        results();
    end
endmodule // sdram_bank_burst_access_bench
`default_nettype wire

//--- verification/sdram_ctrl_model.sv
/*
 * behavioural memory controller that drives the command, address, mask and write data pins
 * assumes one clock shared with the core; the bench calls its tasks, one bus cycle per send
 */
`timescale 1ns/10ps
`default_nettype none
module sdram_ctrl_model
    import sdram_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              extended_temp_variant_in,
    output logic                   cke_out,
    output logic                   cs_n_out,
    output logic                   ras_n_out,
    output logic                   cas_n_out,
    output logic                   we_n_out,
    output logic      [BANK_W-1:0] ba_out,
    output logic      [ROW_W-1:0]  addr_out,
    output logic                   dqm_out,
    output logic      [DATA_W-1:0] dq_out
);
    logic [BANKS-1:0] open_banks;  // rows this controller believes open

    // bus idles deselected with the clock enabled
    initial begin
        cke_out = 1'b1;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
        ba_out = '0;
        addr_out = '0;
        dqm_out = 1'b0;
        dq_out = 16'h5a5a;
        open_banks = '0;
    end

    // one bus cycle: driven just after the edge, held until the next one samples it
    task automatic send(input cmd_type c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic m, input logic x);
        cmd_type k;
        k = c;
        if ((c == CMD_READ || c == CMD_WRITE) && !open_banks[b]) k = CMD_NOP;
        if (c == CMD_ACTIVATE && open_banks[b]) k = CMD_NOP;
        if (c == CMD_REFRESH && !cke_out && extended_temp_variant_in) k = CMD_NOP;
        @(posedge clock_in);
        #1;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = {x | (k == CMD_NOP), k};
        ba_out = b;
        addr_out = a;
        dqm_out = m;
        dq_out = d;
        if (!x && k == CMD_ACTIVATE) open_banks[b] = 1'b1;
        if (!x && k == CMD_PRECHARGE) open_banks = a[10] ? 4'h0 : (open_banks & ~(4'h1 << b));
        if (!x && (k == CMD_READ || k == CMD_WRITE) && a[10]) open_banks[b] = 1'b0;
    endtask

    // clock enable changes only just after an edge
    task automatic set_cke(input logic v);
        @(posedge clock_in);
        #1;
        cke_out = v;
    endtask

    // self refresh entry: refresh with the clock enable dropped in the same cycle, deselect instead on the extended variant
    task automatic enter_self();
        @(posedge clock_in);
        #1;
        cke_out = 1'b0;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = extended_temp_variant_in ? 4'hf : {1'b0, CMD_REFRESH};
    endtask
endmodule // sdram_ctrl_model
`default_nettype wire
